// file: port3_pkg.sv
// Constants shared by the eight-pin I/O port with pull-up control.
package port3_pkg;

  localparam int unsigned PORT_W   = 8;
  localparam int unsigned WB_AW    = 8;
  localparam int unsigned WB_DW    = 32;

  // Register byte offsets.
  localparam logic [7:0] OFF_PIN_DIRECTION   = 8'h00;
  localparam logic [7:0] OFF_PIN_OUTPUT_DATA = 8'h04;
  localparam logic [7:0] OFF_PULLUP_CONTROL  = 8'h08;
  localparam logic [7:0] OFF_HOST_IF_CTRL_A  = 8'h0c;
  localparam logic [7:0] OFF_HOST_IF_CTRL_B  = 8'h10;

  // Field positions of the host channel enables.
  localparam int unsigned HOST_CH1_BIT = 0;
  localparam int unsigned HOST_CH2_BIT = 1;
  localparam int unsigned HOST_CH3_BIT = 2;
  localparam int unsigned HOST_CH4_BIT = 0;

  // Reset values.
  localparam logic [7:0] RST_PIN_DIRECTION   = 8'h00;
  localparam logic [7:0] RST_PIN_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_PULLUP_CONTROL  = 8'h00;
  localparam logic [2:0] RST_HOST_CTRL_A     = 3'h0;
  localparam logic       RST_HOST_CTRL_B     = 1'h0;

endpackage : port3_pkg

// file: pin_sample_if.sv
// Carries raw pin levels to the synchroniser and the settled levels back.
`timescale 1ns/1ps
interface pin_sample_if;
  logic [7:0] raw;
  logic [7:0] sync;
  modport sampler (input raw, output sync);
  modport user    (output raw, input sync);
endinterface : pin_sample_if

// file: pin_sync.sv
// Two-stage synchroniser for the eight external pin levels.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   arst_n_i,
  // Pin levels
  pin_sample_if.sampler pins
);
  import port3_pkg::*;

  logic [PORT_W-1:0] meta_r;
  logic [PORT_W-1:0] meta_nxt;
  logic [PORT_W-1:0] sync_r;
  logic [PORT_W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pins.raw;
    sync_nxt = meta_r;
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pins.sync = sync_r;

endmodule : pin_sync

// file: port3_io.sv
// Eight-pin general-purpose I/O port with pull-ups and host-interface takeover.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module port3_io (
  // Clock and reset
  input  wire logic                         REF_CLK_I,
  input  wire logic                         ARST_N_I,
  // Wishbone slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [port3_pkg::WB_AW-1:0]  WB_ADR_I,
  input  wire logic [3:0]                   WB_SEL_I,
  input  wire logic [port3_pkg::WB_DW-1:0]  WB_DAT_I,
  output logic      [port3_pkg::WB_DW-1:0]  WB_DAT_O,
  output logic                              WB_ACK_O,
  // System mode
  input  wire logic                         SW_STANDBY_I,
  // Package pins
  input  wire logic [port3_pkg::PORT_W-1:0] PIN_I,
  output logic      [port3_pkg::PORT_W-1:0] PIN_O,
  output logic      [port3_pkg::PORT_W-1:0] PIN_OE_O,
  output logic      [port3_pkg::PORT_W-1:0] PULLUP_EN_O,
  // On-chip host interface side
  input  wire logic [port3_pkg::PORT_W-1:0] HOST_PIN_OUT_I,
  input  wire logic [port3_pkg::PORT_W-1:0] HOST_PIN_OE_I,
  output logic      [port3_pkg::PORT_W-1:0] HOST_PIN_IN_O,
  output logic                              HOST_IF_ACTIVE_O
);
  import port3_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser.

  pin_sample_if pins ();

  assign pins.raw = PIN_I;

  pin_sync u_pin_sync (
    .clk_i    (REF_CLK_I),
    .arst_n_i (ARST_N_I),
    .pins     (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Per bit: stored value where the direction is output, pin level where input.
  function automatic logic [PORT_W-1:0] port_read(input logic [PORT_W-1:0] dir,
                                                  input logic [PORT_W-1:0] dat,
                                                  input logic [PORT_W-1:0] lvl);
    port_read = (dir & dat) | (~dir & lvl);
  endfunction : port_read

  // Merges byte lane 0 of a write into an 8-bit register.
  function automatic logic [PORT_W-1:0] lane0(input logic [PORT_W-1:0] old,
                                              input logic [3:0]        sel,
                                              input logic [WB_DW-1:0]  dat);
    lane0 = sel[0] ? dat[PORT_W-1:0] : old;
  endfunction : lane0

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave.

  logic [PORT_W-1:0] pin_direction_r;
  logic [PORT_W-1:0] pin_direction_nxt;
  logic [PORT_W-1:0] pin_output_data_r;
  logic [PORT_W-1:0] pin_output_data_nxt;
  logic [PORT_W-1:0] pullup_control_r;
  logic [PORT_W-1:0] pullup_control_nxt;
  logic [2:0]        host_if_control_a_r;
  logic [2:0]        host_if_control_a_nxt;
  logic              host_if_control_b_r;
  logic              host_if_control_b_nxt;
  logic              ack_r;
  logic              ack_nxt;
  logic [WB_DW-1:0]  rdata_r;
  logic [WB_DW-1:0]  rdata_nxt;
  logic              access;
  logic              wr;

  // Every access is answered one cycle after it is seen, unmapped ones included.
  always_comb begin
    access                = WB_CYC_I && WB_STB_I && !ack_r;
    wr                    = access && WB_WE_I;
    ack_nxt               = access;
    rdata_nxt             = rdata_r;
    pin_direction_nxt     = pin_direction_r;
    pin_output_data_nxt   = pin_output_data_r;
    pullup_control_nxt    = pullup_control_r;
    host_if_control_a_nxt = host_if_control_a_r;
    host_if_control_b_nxt = host_if_control_b_r;
    if (wr) begin
      case (WB_ADR_I)
        OFF_PIN_DIRECTION: begin
          pin_direction_nxt = lane0(pin_direction_r, WB_SEL_I, WB_DAT_I);
        end
        OFF_PIN_OUTPUT_DATA: begin
          pin_output_data_nxt = lane0(pin_output_data_r, WB_SEL_I, WB_DAT_I);
        end
        OFF_PULLUP_CONTROL: begin
          pullup_control_nxt = lane0(pullup_control_r, WB_SEL_I, WB_DAT_I);
        end
        OFF_HOST_IF_CTRL_A: begin
          if (WB_SEL_I[0]) begin
            host_if_control_a_nxt = WB_DAT_I[HOST_CH3_BIT:HOST_CH1_BIT];
          end
        end
        OFF_HOST_IF_CTRL_B: begin
          if (WB_SEL_I[0]) begin
            host_if_control_b_nxt = WB_DAT_I[HOST_CH4_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (access && !WB_WE_I) begin
      rdata_nxt = '0;
      // The direction register is write-only and reads as zero.
      case (WB_ADR_I)
        OFF_PIN_OUTPUT_DATA: begin
          rdata_nxt[PORT_W-1:0] = port_read(pin_direction_r, pin_output_data_r,
                                            pins.sync);
        end
        OFF_PULLUP_CONTROL: begin
          rdata_nxt[PORT_W-1:0] = pullup_control_r;
        end
        OFF_HOST_IF_CTRL_A: begin
          rdata_nxt[HOST_CH3_BIT:HOST_CH1_BIT] = host_if_control_a_r;
        end
        OFF_HOST_IF_CTRL_B: begin
          rdata_nxt[HOST_CH4_BIT] = host_if_control_b_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_direction_r     <= RST_PIN_DIRECTION;
      pin_output_data_r   <= RST_PIN_OUTPUT_DATA;
      pullup_control_r    <= RST_PULLUP_CONTROL;
      host_if_control_a_r <= RST_HOST_CTRL_A;
      host_if_control_b_r <= RST_HOST_CTRL_B;
      ack_r               <= 1'b0;
      rdata_r             <= '0;
    end else begin
      pin_direction_r     <= pin_direction_nxt;
      pin_output_data_r   <= pin_output_data_nxt;
      pullup_control_r    <= pullup_control_nxt;
      host_if_control_a_r <= host_if_control_a_nxt;
      host_if_control_b_r <= host_if_control_b_nxt;
      ack_r               <= ack_nxt;
      rdata_r             <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and pull-up control.

  logic [PORT_W-1:0] pin_out_r;
  logic [PORT_W-1:0] pin_out_nxt;
  logic [PORT_W-1:0] pin_oe_r;
  logic [PORT_W-1:0] pin_oe_nxt;
  logic [PORT_W-1:0] pullup_r;
  logic [PORT_W-1:0] pullup_nxt;
  logic              host_active_r;
  logic              host_active_nxt;

  // Drive and pull-up decisions are registered so the pads see clean levels;
  // the cost is one cycle from a register write to the pin.
  always_comb begin
    host_active_nxt = |host_if_control_a_r | host_if_control_b_r;
    if (host_active_nxt) begin
      pin_out_nxt = HOST_PIN_OUT_I;
      pin_oe_nxt  = HOST_PIN_OE_I;
    end else begin
      pin_out_nxt = pin_output_data_r;
      pin_oe_nxt  = pin_direction_r;
    end
    // A pull-up needs an undriven pin, direction 0 and control 1; a pin that the
    // host interface drives is excluded by the output-enable term.
    pullup_nxt = ~pin_oe_nxt & ~pin_direction_r & pullup_control_r;
    if (SW_STANDBY_I) begin
      pullup_nxt = '0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_out_r     <= '0;
      pin_oe_r      <= '0;
      pullup_r      <= '0;
      host_active_r <= 1'b0;
    end else begin
      pin_out_r     <= pin_out_nxt;
      pin_oe_r      <= pin_oe_nxt;
      pullup_r      <= pullup_nxt;
      host_active_r <= host_active_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign WB_DAT_O         = rdata_r;
  assign WB_ACK_O         = ack_r;
  assign PIN_O            = pin_out_r;
  assign PIN_OE_O         = pin_oe_r;
  assign PULLUP_EN_O      = pullup_r;
  assign HOST_PIN_IN_O    = pins.sync;
  assign HOST_IF_ACTIVE_O = host_active_r;

endmodule : port3_io

// file: port3_io_checker.sv
// Port-level checks on the eight-pin port.
`timescale 1ns/1ps
module port3_io_checker (
  // Clock, reset and bus
  input wire logic        REF_CLK_I,
  input wire logic        ARST_N_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Pins and host side
  input wire logic        SW_STANDBY_I,
  input wire logic [7:0]  PIN_I,
  input wire logic [7:0]  PIN_OE_O,
  input wire logic [7:0]  PULLUP_EN_O,
  input wire logic [7:0]  HOST_PIN_OE_I,
  input wire logic [7:0]  HOST_PIN_IN_O,
  input wire logic        HOST_IF_ACTIVE_O
);
  import port3_pkg::*;
  logic [1:0] run_r;
  logic [1:0] run_nxt;
  // The synchroniser shows zeros just after reset, so its check waits for it to fill.
  always_comb run_nxt = (run_r == 2'h3) ? run_r : run_r + 2'h1;
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) run_r <= 2'h0;
    else run_r <= run_nxt;
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_host_on;
    s_take ##0 (WB_WE_I && WB_SEL_I[0] && ((WB_ADR_I == OFF_HOST_IF_CTRL_A &&
      |WB_DAT_I[HOST_CH3_BIT:HOST_CH1_BIT]) ||
      (WB_ADR_I == OFF_HOST_IF_CTRL_B && WB_DAT_I[HOST_CH4_BIT])));
  endsequence
  AST_ACK_NEXT:
    assert property (s_take |=> WB_ACK_O) else $error("ack missing");
  AST_ACK_PULSE:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  AST_DIR_READ_ZERO:
    assert property (s_take ##0 (!WB_WE_I && WB_ADR_I == OFF_PIN_DIRECTION) |=>
      WB_DAT_O == 32'h0) else $error("direction read not zero");
  AST_DAT_UPPER:
    assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("upper data set");
  AST_HOST_ON:
    assert property (s_host_on |-> ##2 HOST_IF_ACTIVE_O) else $error("host not active");
  AST_HOST_OE:
    assert property (HOST_IF_ACTIVE_O && $past(HOST_IF_ACTIVE_O) && $stable(HOST_PIN_OE_I)
      |-> PIN_OE_O == HOST_PIN_OE_I) else $error("host enable not passed");
  AST_PU_DRIVEN:
    assert property ((PULLUP_EN_O & PIN_OE_O) == 8'h00) else $error("pull-up on driven pin");
  AST_STANDBY:
    assert property ($past(SW_STANDBY_I) |-> PULLUP_EN_O == 8'h00) else $error("standby pull-up");
  AST_SYNC:
    assert property (run_r == 2'h3 |-> HOST_PIN_IN_O == $past(PIN_I, 2)) else $error("sync lag");
endmodule : port3_io_checker
////////////////////////////////////////////////////////////////////////////////
bind port3_io port3_io_checker i_chk (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .SW_STANDBY_I(SW_STANDBY_I), .PIN_I(PIN_I), .PIN_OE_O(PIN_OE_O),
  .PULLUP_EN_O(PULLUP_EN_O), .HOST_PIN_OE_I(HOST_PIN_OE_I),
  .HOST_PIN_IN_O(HOST_PIN_IN_O), .HOST_IF_ACTIVE_O(HOST_IF_ACTIVE_O));

// file: pad_model.sv
// Package pads: device drive, outside sources, pull-ups and floating lines.
`timescale 1ns/1ps
module pad_model (
  // Clock
  input  wire logic       clk_i,
  // Device side
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  // Outside world
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] level_o
);
  logic [7:0] float_r = 8'h5a;
  // An undriven line wanders, so a level an odd number of cycles stale can never pass for a real one.
  always_ff @(posedge clk_i) float_r <= ~float_r;
  always_comb level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i) |
    (~oe_i & ~ext_en_i & (pullup_i | float_r));
endmodule : pad_model

// file: port3_io_test.sv
// Self-checking bench for the eight-pin port.
`timescale 1ns/1ps
module port3_io_test;
  import port3_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, stby = 1'b0;
  logic [7:0]  adr = 8'h00, hout = 8'h00, hoe = 8'h00, ext = 8'h00, edrv = 8'hff;
  logic [7:0]  pin_o, oe, pu, hin, lvl, dir, dat, pcr, lv;
  logic [3:0]  sel = 4'h0, bsel = 4'h1;
  logic [31:0] wdat = 32'h0, dout, rd, lfsr = 32'ha68c002f;
  logic        ack, act;
  int          miscompares = 0, tests_run = 0;
  logic [7:0]  offs[5] = '{OFF_PIN_DIRECTION, OFF_PIN_OUTPUT_DATA, OFF_PULLUP_CONTROL,
                           OFF_HOST_IF_CTRL_A, 8'h20};
  logic [7:0]  rstv[5] = '{8'h00, RST_PIN_OUTPUT_DATA, RST_PULLUP_CONTROL, 8'h00, 8'h00};
  int unsigned chb[4] = '{HOST_CH1_BIT, HOST_CH2_BIT, HOST_CH3_BIT, HOST_CH4_BIT};
  always #5 clk = ~clk;
  port3_io i_dut (.REF_CLK_I(clk), .ARST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dout),
    .WB_ACK_O(ack), .SW_STANDBY_I(stby), .PIN_I(lvl), .PIN_O(pin_o), .PIN_OE_O(oe),
    .PULLUP_EN_O(pu), .HOST_PIN_OUT_I(hout), .HOST_PIN_OE_I(hoe), .HOST_PIN_IN_O(hin),
    .HOST_IF_ACTIVE_O(act));
  pad_model i_pads (.clk_i(clk), .drv_i(pin_o), .oe_i(oe), .pullup_i(pu), .ext_i(ext),
    .ext_en_i(edrv), .level_o(lvl));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  function automatic logic [7:0] exp_data(input logic [7:0] d, v, l);
    return (d & v) | (~d & l);
  endfunction : exp_data
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= bsel;
    wdat <= {24'h0, d};
    // The master waits as long as the slave takes; only the watchdog ends a hang.
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    check("ack wait", 8'(n), 8'h02);
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    check("reset pull-up", pu, 8'h00);
    check("reset enable", oe, 8'h00);
    rst_n <= 1'b1;
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 8'h00);
      check("reset read", rd[7:0], rstv[i]);
    end
    // A write with byte lane 0 disabled must leave the register untouched.
    bsel = 4'he;
    bus(1'b1, OFF_PULLUP_CONTROL, 8'h5a);
    bsel = 4'h1;
    bus(1'b0, OFF_PULLUP_CONTROL, 8'h00);
    check("lane write", rd[7:0], RST_PULLUP_CONTROL);
    bus(1'b0, OFF_HOST_IF_CTRL_B, 8'h00);
    check("reset read", rd[7:0], {7'h0, RST_HOST_CTRL_B});
    $display("reset values done");
    for (int k = 0; k < 24; k++) begin
      lfsr = next_rand(lfsr);
      dir = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : lfsr[7:0];
      dat = lfsr[15:8];
      pcr = lfsr[23:16];
      lv = exp_data(dir, dat, pcr | lfsr[31:24]);
      ext <= lfsr[31:24];
      edrv <= ~dir & ~pcr;
      bus(1'b1, OFF_PIN_DIRECTION, dir);
      bus(1'b1, OFF_PIN_OUTPUT_DATA, dat);
      bus(1'b1, OFF_PULLUP_CONTROL, pcr);
      repeat (4) @(posedge clk);
      check("enable", oe, dir);
      check("drive", pin_o & dir, dat & dir);
      check("pull-up", pu, ~dir & pcr);
      check("synced", hin, lv);
      bus(1'b0, OFF_PIN_OUTPUT_DATA, 8'h00);
      check("data read", rd[7:0], lv);
      stby <= 1'b1;
      repeat (2) @(posedge clk);
      check("standby pull-up", pu, 8'h00);
      stby <= 1'b0;
    end
    $display("pin and pull-up test done");
    edrv <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      hout <= lfsr[7:0];
      hoe <= lfsr[15:8];
      bus(1'b1, i < 3 ? OFF_HOST_IF_CTRL_A : OFF_HOST_IF_CTRL_B, 8'h01 << chb[i]);
      repeat (3) @(posedge clk);
      check("active", {7'h0, act}, 8'h01);
      check("host enable", oe, lfsr[15:8]);
      check("host drive", pin_o & hoe, hout & hoe);
      check("host pull-up", pu & hoe, 8'h00);
      bus(1'b1, i < 3 ? OFF_HOST_IF_CTRL_A : OFF_HOST_IF_CTRL_B, 8'h00);
      repeat (3) @(posedge clk);
      check("inactive", {7'h0, act}, 8'h00);
    end
    $display("host takeover done");
    bus(1'b1, OFF_PIN_DIRECTION, 8'h0f);
    bus(1'b1, OFF_PULLUP_CONTROL, 8'hff);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset pull-up", pu, 8'h00);
    check("reset enable", oe, 8'h00);
    // After the second release the pull-up control and direction registers must be back at their reset values.
    rst_n <= 1'b1;
    bus(1'b0, OFF_PULLUP_CONTROL, 8'h00);
    check("reset read", rd[7:0], RST_PULLUP_CONTROL);
    check("released pull-up", pu, 8'h00);
    check("released enable", oe, 8'h00);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule : port3_io_test
